// ===== rtl/sps_pkg.sv
// Shared constants and types of the serial port select block
package sps_pkg;
  localparam int          APB_ADDR_W   = 8;
  localparam int          APB_DATA_W   = 32;
  localparam int          BYTE_W       = 8;
  localparam int          BIT_CNT_W    = 4;
  localparam int          HALF_W       = 5;

  localparam logic [APB_ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [APB_ADDR_W-1:0] REG_DATA   = 8'h04;
  localparam logic [APB_ADDR_W-1:0] REG_STATUS = 8'h08;
  localparam logic [APB_ADDR_W-1:0] REG_CLEAR  = 8'h0c;
  localparam logic [APB_ADDR_W-1:0] REG_INTEN  = 8'h10;

  localparam logic [1:0]  SEL_3WIRE    = 2'h0;
  localparam logic [1:0]  SEL_INPUT    = 2'h1;

  localparam logic [BIT_CNT_W-1:0] BITS_PER_BYTE = 4'h8;

  // Serial clock half period, a least time
  localparam int          SCK_HALF_NS  = 64;
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [HALF_W-1:0] SCK_HALF_LAST = HALF_W'(SCK_HALF_CYC - 1);

  typedef struct packed {
    logic [1:0] selectModeField;
    logic       masterEnableBit;
    logic       portEnableBit;
  } sps_ctrl_t;

  localparam int          CTRL_W       = 4;
  localparam sps_ctrl_t   CTRL_RESET   = 4'h4;

  typedef struct packed {
    logic modeFaultFlag;
    logic xferDone;
  } sps_status_t;

  localparam int          STATUS_W     = 2;
  localparam sps_status_t STATUS_RESET = 2'h0;
endpackage

// ===== rtl/sps_sync.sv
// Two-flop pin synchroniser with a delayed copy for edge finding
module sps_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout,
  output logic      [W-1:0] doutPrev
);
  logic [W-1:0] stage1;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stage1   <= '0;
      dout     <= '0;
      doutPrev <= '0;
    end else begin
      stage1   <= din;
      dout     <= stage1;
      doutPrev <= dout;
    end
  end
endmodule

// ===== rtl/sps_shifter.sv
// Byte shift register, most significant bit first
module sps_shifter #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         load,
  input  wire logic [W-1:0] loadData,
  input  wire logic         shift,
  input  wire logic         shiftIn,
  output logic      [W-1:0] data
);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      data <= '0;
    end else if (load) begin
      data <= loadData;
    end else if (shift) begin
      data <= {data[W-2:0], shiftIn};
    end
  end
endmodule

// ===== rtl/sps_top.sv
// Serial port with select-line modes and APB registers
//
// Operation
// - Master drives MOSI, slave receives it
// - Master receives MISO, slave drives it
// - Both lines shift most significant bit first
// - Master MOSI comes from shifter top bit
// - MISO released when disabled or unselected
// - Three-wire slave always drives MISO top bit
// - Master makes SCK, slave takes it
// - Unselected four-wire slave ignores SCK
// - Mode 00: three-wire, slave always selected
// - Mode 01: select line is input
// - Select fall disables master in mode 01
// - Mode 1x: select outputs lower mode bit
// - Select routed to pin except mode 00
// - Fault clears both enables, sets fault flag
// - Slave active while select low, fall resets
//
// The APB interface to the registers and the register offsets were left to the implementer.
module sps_top
  import sps_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_ADDR_W-1:0] paddr,
  input  wire logic [APB_DATA_W-1:0] pwdata,
  output logic      [APB_DATA_W-1:0] prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic                       irq,
  input  wire logic                  sckIn,
  output logic                       sckOut,
  output logic                       sckOe,
  input  wire logic                  mosiIn,
  output logic                       mosiOut,
  output logic                       mosiOe,
  input  wire logic                  misoIn,
  output logic                       misoOut,
  output logic                       misoOe,
  input  wire logic                  slaveSelectLineIn,
  output logic                       slaveSelectLineOut,
  output logic                       slaveSelectLineOe,
  output logic                       slaveSelectRouted
);
  sps_ctrl_t               ctrl;
  sps_status_t             status;
  sps_status_t             intEnable;
  logic [BYTE_W-1:0]       rxData;
  logic [BYTE_W-1:0]       shiftData;
  logic [BIT_CNT_W-1:0]    bitCnt;
  logic [HALF_W-1:0]       halfCnt;
  logic                    busy;
  logic                    sckLevel;
  logic                    sampled;
  logic [3:0]              pinSync;
  logic [3:0]              pinPrev;

  // Pin synchronisers: sck, mosi, miso, select
  sps_sync #(
    .W (4)
  ) u_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .din      ({sckIn, mosiIn, misoIn, slaveSelectLineIn}),
    .dout     (pinSync),
    .doutPrev (pinPrev)
  );

  wire sckS      = pinSync[3];
  wire mosiS     = pinSync[2];
  wire misoS     = pinSync[1];
  wire selS      = pinSync[0];
  wire sckRise   = sckS && !pinPrev[3];
  wire sckFall   = !sckS && pinPrev[3];
  wire selFall   = !selS && pinPrev[0];

  // APB decode
  wire apbAccess = psel && penable;
  wire apbWrite  = apbAccess && pwrite;
  wire hitCtrl   = paddr == REG_CTRL;
  wire hitData   = paddr == REG_DATA;
  wire hitStatus = paddr == REG_STATUS;
  wire hitClear  = paddr == REG_CLEAR;
  wire hitInten  = paddr == REG_INTEN;
  wire hitAny    = hitCtrl || hitData || hitStatus || hitClear || hitInten;
  wire ctrlWr    = apbWrite && hitCtrl;
  wire dataWr    = apbWrite && hitData;
  wire clearWr   = apbWrite && hitClear;
  wire intenWr   = apbWrite && hitInten;

  // Role and selection
  wire isMaster   = ctrl.portEnableBit && ctrl.masterEnableBit;
  wire isSlave    = ctrl.portEnableBit && !ctrl.masterEnableBit;
  wire fourWireIn = ctrl.selectModeField == SEL_INPUT;
  wire slaveSel   = isSlave && !(fourWireIn && selS);

  // Engine timing
  wire halfDone  = halfCnt == SCK_HALF_LAST;
  wire mRise     = isMaster && busy && halfDone && !sckLevel;
  wire mFall     = isMaster && busy && halfDone && sckLevel;
  wire sRise     = slaveSel && sckRise;
  wire sFall     = slaveSel && sckFall;
  wire edgeRise  = mRise || sRise;
  wire edgeFall  = mFall || sFall;
  wire lastBit   = bitCnt == BITS_PER_BYTE;
  wire xferDone  = edgeFall && lastBit;
  wire idle      = !busy && bitCnt == '0;
  wire loadTx    = dataWr && ctrl.portEnableBit && idle;
  wire faultEvt  = isMaster && fourWireIn && selFall;
  wire sampleIn  = isMaster ? misoS : mosiS;

  wire [BYTE_W-1:0] shiftedByte = {shiftData[BYTE_W-2:0], sampled};

  sps_shifter #(
    .W (BYTE_W)
  ) u_shift (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .load     (loadTx),
    .loadData (pwdata[BYTE_W-1:0]),
    .shift    (edgeFall),
    .shiftIn  (sampled),
    .data     (shiftData)
  );

  // Control register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
    end else if (faultEvt) begin
      ctrl.masterEnableBit <= 1'b0;
      ctrl.portEnableBit   <= 1'b0;
    end else if (ctrlWr) begin
      ctrl <= sps_ctrl_t'(pwdata[CTRL_W-1:0]);
    end
  end

  // Sticky status, set wins over clear
  wire [STATUS_W-1:0] statusSet = {faultEvt, xferDone};
  wire [STATUS_W-1:0] statusClr = clearWr ? pwdata[STATUS_W-1:0] : '0;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      status <= STATUS_RESET;
    end else begin
      status <= sps_status_t'((status & ~statusClr) | statusSet);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      intEnable <= STATUS_RESET;
    end else if (intenWr) begin
      intEnable <= sps_status_t'(pwdata[STATUS_W-1:0]);
    end
  end

  assign irq = |(status & intEnable);

  // Bit counter
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bitCnt <= '0;
    end else if (!ctrl.portEnableBit) begin
      bitCnt <= '0;
    end else if (isSlave && fourWireIn && selFall) begin
      bitCnt <= '0;
    end else if (edgeRise) begin
      bitCnt <= bitCnt + 1'b1;
    end else if (xferDone) begin
      bitCnt <= '0;
    end
  end

  // Master sequencing
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      busy <= 1'b0;
    end else if (!isMaster || xferDone) begin
      busy <= 1'b0;
    end else if (loadTx) begin
      busy <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      halfCnt <= '0;
    end else if (!busy || halfDone) begin
      halfCnt <= '0;
    end else begin
      halfCnt <= halfCnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sckLevel <= 1'b0;
    end else if (!busy || !isMaster) begin
      sckLevel <= 1'b0;
    end else if (halfDone) begin
      sckLevel <= !sckLevel;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sampled <= 1'b0;
    end else if (edgeRise) begin
      sampled <= sampleIn;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rxData <= '0;
    end else if (xferDone) begin
      rxData <= shiftedByte;
    end
  end

  // Read mux, zero wait
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hitAny;
  assign prdata  = hitCtrl   ? APB_DATA_W'(ctrl) :
                   hitData   ? APB_DATA_W'(rxData) :
                   hitStatus ? APB_DATA_W'(status) :
                   hitInten  ? APB_DATA_W'(intEnable) : '0;

  assign mosiOut = shiftData[BYTE_W-1];
  assign mosiOe  = isMaster;
  assign misoOut = shiftData[BYTE_W-1];
  assign misoOe  = slaveSel;
  assign sckOut  = sckLevel;
  assign sckOe   = isMaster;
  assign slaveSelectLineOut = ctrl.selectModeField[0];
  assign slaveSelectLineOe  = ctrl.selectModeField[1];
  assign slaveSelectRouted  = ctrl.selectModeField != SEL_3WIRE;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  property p_mosi_dir;
    (ctrl.portEnableBit && ctrl.masterEnableBit) |-> mosiOe && !misoOe;
  endproperty
  a_mosi_dir: assert property (p_mosi_dir) else $error("master pin directions wrong");

  property p_miso_slave;
    (isSlave && !fourWireIn) |-> misoOe && !mosiOe && !sckOe;
  endproperty
  a_miso_slave: assert property (p_miso_slave) else $error("slave pin directions wrong");

  property p_msb_first;
    (mFall && !lastBit) |=> mosiOut == $past(shiftData[BYTE_W-2]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("shift not msb first");

  property p_mosi_src;
    (isMaster && $rose(busy)) |-> mosiOut == $past(pwdata[BYTE_W-1]);
  endproperty
  a_mosi_src: assert property (p_mosi_src) else $error("mosi not from top bit");

  property p_miso_hiz;
    (!ctrl.portEnableBit || (fourWireIn && selS && !ctrl.masterEnableBit)) |-> !misoOe;
  endproperty
  a_miso_hiz: assert property (p_miso_hiz) else $error("miso driven while released");

  property p_three_wire_slave;
    (isSlave && ctrl.selectModeField == SEL_3WIRE) |-> misoOe && misoOut == shiftData[BYTE_W-1];
  endproperty
  a_three_wire_slave: assert property (p_three_wire_slave) else $error("3-wire slave miso");

  property p_sck_gen;
    (mRise && !faultEvt) |=> sckOut && sckOe;
  endproperty
  a_sck_gen: assert property (p_sck_gen) else $error("master sck not raised");

  property p_ignore_sck;
    (isSlave && fourWireIn && selS && !ctrlWr) |=> bitCnt == $past(bitCnt);
  endproperty
  a_ignore_sck: assert property (p_ignore_sck) else $error("unselected slave counted");

  sequence s_fault;
    faultEvt;
  endsequence
  sequence s_disabled;
    !ctrl.masterEnableBit && !ctrl.portEnableBit && status.modeFaultFlag;
  endsequence
  property p_fault;
    s_fault |=> s_disabled ##1 !mosiOe;
  endproperty
  a_fault: assert property (p_fault) else $error("mode fault not taken");

  property p_sel_out;
    ctrl.selectModeField[1] |-> slaveSelectLineOe && slaveSelectLineOut == ctrl.selectModeField[0];
  endproperty
  a_sel_out: assert property (p_sel_out) else $error("select output wrong");

  property p_routed;
    (ctrl.selectModeField == SEL_3WIRE) |-> !slaveSelectRouted && !slaveSelectLineOe;
  endproperty
  a_routed: assert property (p_routed) else $error("select routed in 3-wire");

  property p_sel_fall;
    (isSlave && fourWireIn && selFall) |=> bitCnt == '0;
  endproperty
  a_sel_fall: assert property (p_sel_fall) else $error("select fall kept count");
endmodule

// ===== tb/sps_peer.sv
// Behavioural far-side device, slave to a master port or master to a slave port
module sps_peer (
  input  wire logic sckPin,
  input  wire logic mosiPin,
  input  wire logic misoPin,
  input  wire logic ssPin,
  output logic      peerSck,
  output logic      peerMosi,
  output logic      peerMiso,
  output logic      peerMisoOe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sh;
  logic       inBit;
  logic       isMaster;
  logic       slaveOn;
  assign peerMosi = sh[7];
  assign peerMiso = sh[7];
  assign peerMisoOe = slaveOn & ~isMaster & ~ssPin;
  initial begin
    {sh, inBit, isMaster, slaveOn, peerSck} = '0;
  end
  always @(posedge sckPin) begin
    inBit <= isMaster ? misoPin : mosiPin;
  end
  always @(negedge sckPin) begin
    sh <= {sh[6:0], inBit};
  end
  task automatic set_slave(input logic [7:0] b, input logic on);
    isMaster = 1'b0;
    slaveOn = on;
    sh = b;
  endtask
  task automatic send(input logic [7:0] b, input int nb);
    isMaster = 1'b1;
    sh = b;
    repeat (nb) begin
      #62.5 peerSck = 1'b1;
      #62.5 peerSck = 1'b0;
    end
  endtask
endmodule

// ===== tb/sps_top_bench.sv
// Self-checking bench of the serial port select block
module sps_top_bench
  import sps_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic                  clk_sys, reset, psel, penable, pwrite, pready, pslverr, irq, err, ssDrv;
  logic [APB_ADDR_W-1:0] paddr;
  logic [APB_DATA_W-1:0] pwdata, prdata, q;
  logic                  sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe;
  logic                  slaveSelectLineOut, slaveSelectLineOe, slaveSelectRouted;
  logic                  peerSck, peerMosi, peerMiso, peerMisoOe;
  logic [7:0]            tb, rb;
  int                    n_fail, n_compared, seed, n;
  wire logic sckIn = sckOe ? sckOut : peerSck;
  wire logic mosiIn = mosiOe ? mosiOut : (peer_u.isMaster ? peerMosi : ~peerMosi);
  wire logic misoIn = misoOe ? misoOut : (peerMisoOe ? peerMiso : ~peerMiso);
  wire logic slaveSelectLineIn = slaveSelectLineOe ? slaveSelectLineOut : ssDrv;
  sps_top dut_u (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
    .sckIn, .sckOut, .sckOe, .mosiIn, .mosiOut, .mosiOe, .misoIn, .misoOut, .misoOe, .slaveSelectLineIn,
    .slaveSelectLineOut, .slaveSelectLineOe, .slaveSelectRouted);
  sps_peer peer_u (.sckPin(sckIn), .mosiPin(mosiIn), .misoPin(misoIn), .ssPin(slaveSelectLineIn), .peerSck,
    .peerMosi, .peerMiso, .peerMisoOe);
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic print_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask
  function automatic logic [31:0] ctrl(input logic [1:0] m, input logic ms, input logic en);
    return {28'h0, m, ms, en};
  endfunction
  task automatic settle(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      n_fail++;
      print_verdict();
    end else begin
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic rd_cmp(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp_word(q, e);
  endtask
  task automatic wait_irq();
    for (n = 0; n < 1000 && irq !== 1'b1; n++) @(posedge clk_sys);
    if (n == 1000) begin
      n_fail++;
      print_verdict();
    end
  endtask
  task automatic slave_xfer(input logic [7:0] t, input logic [7:0] r);
    apb(1'b1, REG_DATA, {24'h0, t});
    settle(1);
    cmp_bit(misoOut, t[7]);
    peer_u.send(r, 8);
    settle(6);
    cmp_bit(irq, 1'b1);
    cmp_word({24'h0, peer_u.sh}, {24'h0, t});
    rd_cmp(REG_DATA, {24'h0, r});
    apb(1'b1, REG_CLEAR, 32'h1);
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ssDrv = 1'b1;
    reset = 1'b1;
    seed = 8;
    n_fail = 0;
    n_compared = 0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    settle(1);
    cmp_bit(slaveSelectRouted & ~slaveSelectLineOe, 1'b1);
    cmp_bit(misoOe | mosiOe | sckOe, 1'b0);
    rd_cmp(REG_CTRL, 32'(CTRL_RESET));
    rd_cmp(REG_STATUS, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    cmp_bit(err, 1'b1);
    cmp_word(q, 32'h0);
    $display("end reset");
    apb(1'b1, REG_INTEN, 32'h1);
    for (int i = 0; i < 3; i++) begin
      tb = (i == 0) ? 8'h81 : 8'($random(seed));
      rb = (i == 0) ? 8'h7e : 8'($random(seed));
      peer_u.set_slave(rb, 1'b1);
      apb(1'b1, REG_CTRL, ctrl(2'h2, 1'b1, 1'b1));
      settle(1);
      cmp_bit(slaveSelectLineOut, 1'b0);
      cmp_bit(slaveSelectLineOe & slaveSelectRouted & mosiOe & sckOe & ~misoOe, 1'b1);
      apb(1'b1, REG_DATA, {24'h0, tb});
      settle(2);
      cmp_bit(mosiOut, tb[7]);
      wait_irq();
      settle(2);
      cmp_word({24'h0, peer_u.sh}, {24'h0, tb});
      rd_cmp(REG_DATA, {24'h0, rb});
      apb(1'b1, REG_CLEAR, 32'h3);
      settle(1);
      cmp_bit(irq, 1'b0);
    end
    apb(1'b1, REG_CTRL, ctrl(2'h3, 1'b1, 1'b1));
    settle(1);
    cmp_bit(slaveSelectLineOut, 1'b1);
    $display("end master");
    peer_u.set_slave(8'h0, 1'b0);
    apb(1'b1, REG_INTEN, 32'h2);
    apb(1'b1, REG_CTRL, ctrl(2'h1, 1'b1, 1'b1));
    settle(4);
    ssDrv <= 1'b0;
    settle(8);
    cmp_bit(sckOe | mosiOe, 1'b0);
    cmp_bit(irq, 1'b1);
    rd_cmp(REG_CTRL, ctrl(2'h1, 1'b0, 1'b0));
    rd_cmp(REG_STATUS, 32'h2);
    apb(1'b1, REG_CLEAR, 32'h3);
    $display("end fault");
    apb(1'b1, REG_INTEN, 32'h1);
    ssDrv <= 1'b1;
    apb(1'b1, REG_CTRL, ctrl(2'h0, 1'b0, 1'b0));
    settle(1);
    cmp_bit(misoOe | slaveSelectRouted, 1'b0);
    apb(1'b1, REG_CTRL, ctrl(2'h0, 1'b0, 1'b1));
    settle(1);
    cmp_bit(misoOe, 1'b1);
    slave_xfer(8'($random(seed)), 8'($random(seed)));
    $display("end slave3");
    apb(1'b1, REG_CTRL, ctrl(2'h1, 1'b0, 1'b1));
    settle(4);
    cmp_bit(misoOe, 1'b0);
    peer_u.send(8'($random(seed)), 8);
    settle(6);
    cmp_bit(irq, 1'b0);
    ssDrv <= 1'b0;
    settle(4);
    cmp_bit(misoOe, 1'b1);
    peer_u.send(8'($random(seed)), 3);
    settle(6);
    ssDrv <= 1'b1;
    settle(4);
    cmp_bit(misoOe | irq, 1'b0);
    ssDrv <= 1'b0;
    settle(4);
    slave_xfer(8'($random(seed)), 8'($random(seed)));
    $display("end slave4");
    print_verdict();
  end
endmodule
